// File: rtl/sds_pkg.sv
`default_nettype none
package sds_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned DIFF_MAX_HZ  = 10000;
    localparam int unsigned OC_MAX_HZ    = 500;
    localparam int unsigned STEP_IDLE_US = 1000;
    localparam int unsigned BLINK_MS     = 200;
    localparam int unsigned DIFF_MIN_CYC = (CLK_MHZ * 1000000 + DIFF_MAX_HZ - 1) / DIFF_MAX_HZ;
    localparam int unsigned OC_MIN_CYC   = (CLK_MHZ * 1000000 + OC_MAX_HZ - 1) / OC_MAX_HZ;
    localparam int unsigned IDLE_CYC     = STEP_IDLE_US * CLK_MHZ;
    localparam int unsigned BLINK_CYC    = BLINK_MS * 1000 * CLK_MHZ;
    localparam int unsigned SYNC_WIDTH   = 16;

    // ****************************************
    // resolution and timing output period
    // ****************************************
    localparam int unsigned QUAD         = 4;
    localparam int unsigned TIM_DIV      = 50;
    localparam int unsigned RES_A_FIRST  = 1000;
    localparam int unsigned RES_A_SECOND = 10000;
    localparam int unsigned RES_B_FIRST  = 500;
    localparam int unsigned RES_B_SECOND = 5000;
    localparam logic [11:0] TPER_A1 = 12'(RES_A_FIRST * QUAD / TIM_DIV);
    localparam logic [11:0] TPER_A2 = 12'(RES_A_SECOND * QUAD / TIM_DIV);
    localparam logic [11:0] TPER_B1 = 12'(RES_B_FIRST * QUAD / TIM_DIV);
    localparam logic [11:0] TPER_B2 = 12'(RES_B_SECOND * QUAD / TIM_DIV);

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [3:0]  CTRL_OFF    = 4'h0;
    localparam logic [3:0]  ENDWIN_OFF  = 4'h4;
    localparam logic [3:0]  STATUS_OFF  = 4'h8;
    localparam logic [3:0]  DIALS_OFF   = 4'hC;
    localparam int unsigned CTRL_ALCODE = 0;
    localparam int unsigned CTRL_WNG_EN = 1;
    localparam int unsigned CTRL_WNG_SRC = 2;
    localparam int unsigned CTRL_PUSH   = 3;
    localparam int unsigned CTRL_EXC_NC = 4;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [15:0] ENDWIN_RST  = 16'h00B4;

    // ****************************************
    // speed filter dial, time constant in ms
    // ****************************************
    localparam logic [7:0] FILT_MS [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0A, 8'h14,
                                            8'h1E, 8'h32, 8'h46, 8'h64, 8'h78, 8'h96, 8'hAA, 8'hC8};
endpackage
`default_nettype wire

// File: rtl/sds_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sds_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } sds_sync_t;

    sds_sync_t s_q;
    sds_sync_t s_d;

    // two stages, only the second is read
    always_comb begin
        s_d.meta = din;
        s_d.stab = s_q.meta;
    end

    // registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.stab;
endmodule // sds_sync
`default_nettype wire

// File: rtl/sds_status.sv
// Functional notes
// R1 - ready goes high once initialised and the motor can take step pulses
// R2 - controller sends no step pulses before it sees ready
// R3 - alarm code on ready, torque-limit and timing-oc lines when enabled and alarmed
// R4 - torque-limit high on torque overrange or while pushing with push current set
// R5 - motion complete only with no step input and deviation inside window
// R6 - timing outputs pulse every 7.2 degrees of shaft rotation
// R7 - diff timing valid up to 10 kHz, open-collector up to 500 Hz
// R8 - resolution select toggled off-condition stops timing pulses
// R9 - phase A pulses per revolution follow resolution at power-up
// R10 - phase B lags or leads A by 90 degrees, level shows direction
// R11 - feedback lags motion by at most 0.1 ms
// R12 - warning output when enabled, source defaults to alarm conditions
// R13 - alarm drops alarm output, blinks indicator, cuts current, holds brake
// R14 - abnormal operation data alarm keeps motor current on
// R15 - alarm cause shown as number of indicator blinks
// R16 - controller stops motion commands once alarm output is low
// R17 - excitation then energise, then ready
// R18 - resolution switches sampled only at power-up
// R19 - resolution select ignored while second resolution switch set
// R20 - pulse mode switch read at power-up, step+dir or cw/ccw
// R21 - current dial 0..F gives rate in 6.25 percent steps
// R22 - speed filter dial maps to fixed time constant table
// R23 - motor energised only while excitation input active, polarity selectable
// R24 - resettable alarm cleared on falling edge of alarm clear input
// R25 - no alarm means shared lines keep their normal meaning
// R26 - motion complete low during step input or alarm current cut
`timescale 1ns/1ps
`default_nettype none
module sds_status
    import sds_pkg::*;
#(
    parameter int unsigned DIFF_CYC = sds_pkg::DIFF_MIN_CYC,
    parameter int unsigned OC_CYC   = sds_pkg::OC_MIN_CYC,
    parameter int unsigned IDL_CYC  = sds_pkg::IDLE_CYC,
    parameter int unsigned BLK_CYC  = sds_pkg::BLINK_CYC
) (
    input  wire logic               CLK,
    input  wire logic               RESETN,
    input  wire logic               WB_CYC_I,
    input  wire logic               WB_STB_I,
    input  wire logic               WB_WE_I,
    input  wire logic [3:0]         WB_ADR_I,
    input  wire logic [3:0]         WB_SEL_I,
    input  wire logic [31:0]        WB_DAT_I,
    output logic      [31:0]        WB_DAT_O,
    output logic                    WB_ACK_O,
    input  wire logic               EXCITE_IN,
    input  wire logic               STEP_PULSE_IN,
    input  wire logic               STEP_DIR_IN,
    input  wire logic               ALARM_CLEAR_IN,
    input  wire logic               RES_SELECT_IN,
    input  wire logic               RES_SECOND_SW,
    input  wire logic               RES_TABLE_B_SW,
    input  wire logic               PULSE_2P_SW,
    input  wire logic [3:0]         CURRENT_DIAL,
    input  wire logic [3:0]         SPEED_FILTER_DIAL,
    input  wire logic               TORQUE_OVER_IN,
    input  wire logic               PUSH_ACTIVE_IN,
    input  wire logic signed [15:0] DEVIATION_IN,
    input  wire logic               ROTOR_QSTEP_IN,
    input  wire logic               ROTOR_FWD_IN,
    input  wire logic               FAULT_IN,
    input  wire logic [2:0]         FAULT_CODE_IN,
    input  wire logic               FAULT_RESETTABLE_IN,
    input  wire logic               FAULT_KEEP_CURRENT_IN,
    input  wire logic               WARN_IN,
    output logic                    READY_OUT,
    output logic                    TORQUE_LIMIT_OUT,
    output logic                    END_OUT,
    output logic                    TIMING_OUT_DIFF,
    output logic                    TIMING_OUT_OC,
    output logic                    FEEDBACK_PHASE_A,
    output logic                    FEEDBACK_PHASE_B,
    output logic                    WARNING_OUT,
    output logic                    ALARM_OUT,
    output logic                    ALARM_LED,
    output logic                    MOTOR_ENABLE,
    output logic                    BRAKE_HOLD,
    output logic                    RES_SECOND_ACTIVE,
    output logic                    PULSE_MODE_2P,
    output logic [4:0]              CURRENT_RATE,
    output logic [7:0]              FILTER_MS
);
    import sds_pkg::*;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] endwin;
        logic        ack;
        logic [31:0] rdat;
        logic [1:0]  init;
        logic        res_sec;
        logic        res_tab_b;
        logic        pm_2p;
        logic        a_prev;
        logic        b_prev;
        logic        cs_prev;
        logic        clr_prev;
        logic [31:0] gap;
        logic [31:0] last_gap;
        logic [11:0] tpos;
        logic        tim_lost;
        logic [1:0]  quad;
        logic        alarm_out;
        logic        keep;
        logic        rst_ok;
        logic [2:0]  code;
        logic [31:0] blk;
        logic [4:0]  slot;
        logic        ready;
        logic        torque_limit_out;
        logic        endo;
        logic        timd;
        logic        timo;
        logic        pha;
        logic        phb;
        logic        warning_out;
        logic        almo;
        logic        led;
        logic        moten;
        logic        brake;
        logic        res_act;
        logic [4:0]  cur;
        logic [7:0]  filt;
    } sds_state_t;

    sds_state_t s_q;
    sds_state_t s_d;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [SYNC_WIDTH-1:0] pins;
    logic                  exc_n;
    logic                  a_n;
    logic                  b_n;
    logic                  clr_n;
    logic                  cs_n;
    logic                  sec_n;
    logic                  tab_n;
    logic                  p2_n;
    logic [3:0]            cur_n;
    logic [3:0]            fil_n;

    sds_sync #(.W(SYNC_WIDTH)) u_sync (
        .clk    (CLK),
        .resetn (RESETN),
        .din    ({EXCITE_IN, STEP_PULSE_IN, STEP_DIR_IN, ALARM_CLEAR_IN, RES_SELECT_IN,
                  RES_SECOND_SW, RES_TABLE_B_SW, PULSE_2P_SW, CURRENT_DIAL, SPEED_FILTER_DIAL}),
        .dout   (pins)
    );
    assign {exc_n, a_n, b_n, clr_n, cs_n, sec_n, tab_n, p2_n, cur_n, fil_n} = pins;

    // ****************************************
    // next state
    // ****************************************
    logic        step_ev;
    logic        idle;
    logic        diff_ok;
    logic        oc_ok;
    logic        tim_on;
    logic        cut;
    logic        alsel;
    logic        clr_fall;
    logic [11:0] tper;
    logic [15:0] dev_abs;
    logic        wr;

    always_comb begin
        s_d = s_q;
        // bus slave, one wait state, unmapped reads zero
        wr = WB_CYC_I && WB_STB_I && !s_q.ack;
        s_d.ack = wr;
        s_d.rdat = '0;
        if (wr && WB_WE_I) begin
            for (int i = 0; i < 4; i++) begin
                if (WB_SEL_I[i] && WB_ADR_I == CTRL_OFF) begin
                    s_d.ctrl[i*8 +: 8] = WB_DAT_I[i*8 +: 8];
                end
            end
            // window is 16 bits, upper lanes ignored
            if (WB_SEL_I[0] && WB_ADR_I == ENDWIN_OFF) begin
                s_d.endwin[7:0] = WB_DAT_I[7:0];
            end
            if (WB_SEL_I[1] && WB_ADR_I == ENDWIN_OFF) begin
                s_d.endwin[15:8] = WB_DAT_I[15:8];
            end
        end
        if (wr && !WB_WE_I) begin
            unique case (WB_ADR_I)
                CTRL_OFF:   s_d.rdat = s_q.ctrl;
                ENDWIN_OFF: s_d.rdat = {16'h0000, s_q.endwin};
                STATUS_OFF: s_d.rdat = {20'h0_0000, s_q.tim_lost, s_q.pm_2p, s_q.res_act, s_q.moten,
                                        s_q.code, s_q.keep, s_q.rst_ok, s_q.alarm_out, s_q.ready, s_q.init == 2'd3};
                DIALS_OFF:  s_d.rdat = {19'h0_0000, s_q.cur, s_q.filt};
                default:    s_d.rdat = '0;
            endcase
        end

        // power-up capture of the switches once synchronised
        if (s_q.init != 2'd3) begin
            s_d.init = s_q.init + 2'd1;
        end
        if (s_q.init == 2'd2) begin
            s_d.res_sec = sec_n;   // R18
            s_d.res_tab_b = tab_n; // R18
            s_d.pm_2p = p2_n;      // R20
        end
        unique case ({s_q.res_tab_b, s_q.res_sec})
            2'b00: tper = TPER_A1;
            2'b01: tper = TPER_A2;
            2'b10: tper = TPER_B1;
            2'b11: tper = TPER_B2;
        endcase

        // step input watch, 2p with both edges together counts as none
        s_d.a_prev = a_n;
        s_d.b_prev = b_n;
        step_ev = s_q.pm_2p ? ((a_n && !s_q.a_prev) ^ (b_n && !s_q.b_prev)) : (a_n && !s_q.a_prev); // R20
        s_d.gap = step_ev ? '0 : ((s_q.gap < OC_CYC) ? s_q.gap + 32'h0000_0001 : s_q.gap);
        if (step_ev) begin
            s_d.last_gap = s_q.gap;
        end
        idle = s_q.gap >= IDL_CYC;
        diff_ok = s_q.last_gap >= DIFF_CYC || s_q.gap >= DIFF_CYC; // R7
        oc_ok = s_q.last_gap >= OC_CYC || s_q.gap >= OC_CYC;       // R7

        // shaft position within one 7.2 degree period and quadrature phase
        if (ROTOR_QSTEP_IN) begin
            if (ROTOR_FWD_IN) begin
                s_d.tpos = (s_q.tpos >= tper - 12'h001) ? 12'h000 : s_q.tpos + 12'h001; // R6
                s_d.quad = s_q.quad + 2'd1; // R9
            end else begin
                s_d.tpos = (s_q.tpos == 12'h000) ? tper - 12'h001 : s_q.tpos - 12'h001; // R6
                s_d.quad = s_q.quad - 2'd1; // R9
            end
        end
        s_d.pha = s_d.quad == 2'd1 || s_d.quad == 2'd2; // R9 R11
        s_d.phb = s_d.quad[1];                          // R10
        tim_on = s_q.tpos == 12'h000 && !s_q.tim_lost;  // R6

        // resolution select input
        s_d.cs_prev = cs_n;
        if (s_q.init == 2'd3 && !s_q.res_sec && (cs_n ^ s_q.cs_prev) && !(tim_on && idle)) begin
            s_d.tim_lost = 1'b1; // R8
        end
        s_d.res_act = s_q.res_sec || cs_n; // R19

        // alarm latch, a new fault wins over the clear edge
        s_d.clr_prev = clr_n;
        clr_fall = s_q.clr_prev && !clr_n;
        if (s_q.alarm_out && s_q.rst_ok && clr_fall) begin
            s_d.alarm_out = 1'b0; // R24
        end
        if (FAULT_IN && !s_d.alarm_out) begin
            s_d.alarm_out = 1'b1;
            s_d.code = FAULT_CODE_IN;
            s_d.rst_ok = FAULT_RESETTABLE_IN;
            s_d.keep = FAULT_KEEP_CURRENT_IN; // R14
        end

        // indicator blinks code+1 times then stays dark five slots
        if (!s_q.alarm_out) begin
            s_d.blk = '0;
            s_d.slot = '0;
        end else if (s_q.blk >= BLK_CYC - 1) begin
            s_d.blk = '0;
            s_d.slot = (s_q.slot >= {1'b0, s_q.code, 1'b0} + 5'd5) ? 5'd0 : s_q.slot + 5'd1;
        end else begin
            s_d.blk = s_q.blk + 32'h0000_0001;
        end
        s_d.led = s_q.alarm_out && !s_q.slot[0] && s_q.slot < {1'b0, s_q.code, 1'b0} + 5'd2; // R13 R15

        // excitation, current cut and brake
        cut = s_q.alarm_out && !s_q.keep;                                              // R13 R14
        s_d.moten = (exc_n ^ s_q.ctrl[CTRL_EXC_NC]) && s_q.init == 2'd3 && !cut; // R23 R17
        s_d.brake = !s_d.moten;                                                  // R13

        // status outputs, shared lines muxed with the alarm code
        alsel = s_q.alarm_out && s_q.ctrl[CTRL_ALCODE];
        s_d.ready = alsel ? s_q.code[0] : (s_q.moten && !s_q.alarm_out); // R3 R25 R1 R17
        s_d.torque_limit_out = alsel ? s_q.code[1]
                        : (TORQUE_OVER_IN || (PUSH_ACTIVE_IN && s_q.ctrl[CTRL_PUSH])); // R3 R25 R4
        s_d.timo = alsel ? s_q.code[2] : (tim_on && oc_ok); // R3 R25 R6 R7
        s_d.timd = tim_on && diff_ok;                       // R6 R7
        dev_abs = DEVIATION_IN[15] ? 16'(-DEVIATION_IN) : 16'(DEVIATION_IN);
        s_d.endo = idle && !step_ev && !cut && dev_abs <= s_q.endwin; // R5 R26
        s_d.warning_out = s_q.ctrl[CTRL_WNG_EN] && (s_q.ctrl[CTRL_WNG_SRC] ? WARN_IN : s_q.alarm_out); // R12
        s_d.almo = !s_q.alarm_out; // R13

        // dials
        s_d.cur = {1'b0, cur_n} + 5'd1; // R21
        s_d.filt = FILT_MS[fil_n];      // R22
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RST;
            s_q.endwin <= ENDWIN_RST;
            s_q.last_gap <= 32'hFFFF_FFFF;
            s_q.brake <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign WB_DAT_O = s_q.rdat;
    assign WB_ACK_O = s_q.ack;
    assign READY_OUT = s_q.ready;
    assign TORQUE_LIMIT_OUT = s_q.torque_limit_out;
    assign END_OUT = s_q.endo;
    assign TIMING_OUT_DIFF = s_q.timd;
    assign TIMING_OUT_OC = s_q.timo;
    assign FEEDBACK_PHASE_A = s_q.pha;
    assign FEEDBACK_PHASE_B = s_q.phb;
    assign WARNING_OUT = s_q.warning_out;
    assign ALARM_OUT = s_q.almo;
    assign ALARM_LED = s_q.led;
    assign MOTOR_ENABLE = s_q.moten;
    assign BRAKE_HOLD = s_q.brake;
    assign RES_SECOND_ACTIVE = s_q.res_act;
    assign PULSE_MODE_2P = s_q.pm_2p;
    assign CURRENT_RATE = s_q.cur;
    assign FILTER_MS = s_q.filt;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence s_clr_req;
        s_q.alarm_out && s_q.rst_ok && clr_fall && !FAULT_IN;
    endsequence
    sequence s_clr_done;
        !s_q.alarm_out ##1 ALARM_OUT;
    endsequence

    property p_alcode;
        s_q.alarm_out && s_q.ctrl[CTRL_ALCODE] |=> READY_OUT == $past(s_q.code[0]) && TORQUE_LIMIT_OUT == $past(s_q.code[1])
                                            && TIMING_OUT_OC == $past(s_q.code[2]);
    endproperty
    a_alcode: assert property (p_alcode) else $error("alarm code not on shared lines"); // R3

    property p_cut;
        s_q.alarm_out && !s_q.keep |=> !MOTOR_ENABLE && BRAKE_HOLD && !ALARM_OUT;
    endproperty
    a_cut: assert property (p_cut) else $error("alarm did not cut current"); // R13

    property p_keep;
        s_q.alarm_out && s_q.keep && s_q.moten && !FAULT_IN && (exc_n ^ s_q.ctrl[CTRL_EXC_NC]) |=> MOTOR_ENABLE;
    endproperty
    a_keep: assert property (p_keep) else $error("data alarm cut current"); // R14

    property p_end_step;
        step_ev |-> ##1 !END_OUT ##1 !END_OUT;
    endproperty
    a_end_step: assert property (p_end_step) else $error("end high during step input"); // R26

    property p_clear;
        s_clr_req |=> s_clr_done;
    endproperty
    a_clear: assert property (p_clear) else $error("alarm clear edge ignored"); // R24

    property p_dir;
        ROTOR_QSTEP_IN && ROTOR_FWD_IN && s_q.quad == 2'd0 |=> FEEDBACK_PHASE_A && !FEEDBACK_PHASE_B;
    endproperty
    a_dir: assert property (p_dir) else $error("phase b wrong at phase a rise"); // R10

    property p_ready;
        READY_OUT && ALARM_OUT |-> $past(MOTOR_ENABLE);
    endproperty
    a_ready: assert property (p_ready) else $error("ready before energise"); // R17

    property p_tim_rate;
        TIMING_OUT_DIFF |-> $past(diff_ok) && $past(s_q.tpos) == 12'h000;
    endproperty
    a_tim_rate: assert property (p_tim_rate) else $error("diff timing out of rate"); // R7

    property p_tim_lost;
        s_q.tim_lost |=> !TIMING_OUT_DIFF [*3];
    endproperty
    a_tim_lost: assert property (p_tim_lost) else $error("timing pulse after bad select"); // R8

    property p_tlc;
        TORQUE_OVER_IN && !(s_q.alarm_out && s_q.ctrl[CTRL_ALCODE]) |=> TORQUE_LIMIT_OUT;
    endproperty
    a_tlc: assert property (p_tlc) else $error("torque limit not shown"); // R4
endmodule // sds_status
`default_nettype wire

// File: test/sds_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// controller model: step pulse source
// ****************************************
module sds_ctrl_model (
    input  wire logic clk,
    input  wire logic ready,
    input  wire logic alarm_ok,
    input  wire logic run,
    output logic      step
);
    int cnt;
    initial step = 1'b0;
    initial cnt = 0;
    // 10-cycle pulse every 100 cycles, only while ready and alarm-free
    always @(posedge clk) begin
        if (run && ready && alarm_ok) begin
            cnt <= (cnt == 99) ? 0 : cnt + 1;
            step <= (cnt < 10);
        end else begin
            cnt <= 0;
            step <= 1'b0;
        end
    end
endmodule // sds_ctrl_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sds_pkg::*;
    logic        clk_r = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack;
    logic [3:0]  adr = 0, sel = 0, cdial = 4'h6, fdial = 4'h9;
    logic [31:0] wdat = 0, rdat, q;
    logic        exc = 0, dir = 1, clr = 0, torq = 0, push = 0, qstep = 0, fwd = 1;
    logic        flt = 0, keep = 0, resbl = 1, run = 0, rsel = 0, res2sw = 0, tbsw = 0, p2sw = 1, warn = 0;
    logic [2:0]  code = 0;
    logic signed [15:0] dev = 0;
    logic        step, rdy, torque_limit_out, endo, tdiff, toc, pa, pb, warning_out, alarm_out, led, men, brk, res2, p2;
    logic [4:0]  rate;
    logic [7:0]  fms;
    int          n_errors = 0, total_checks = 0, nd = 0, no = 0, p;

    // ****************************************
    // clock, design and controller model
    // ****************************************
    always #2.5 clk_r = ~clk_r;

    sds_status #(.DIFF_CYC(20), .OC_CYC(40), .IDL_CYC(10), .BLK_CYC(4)) dut_u (
        .CLK(clk_r), .RESETN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .EXCITE_IN(exc),
        .STEP_PULSE_IN(step), .STEP_DIR_IN(dir), .ALARM_CLEAR_IN(clr), .RES_SELECT_IN(rsel),
        .RES_SECOND_SW(res2sw), .RES_TABLE_B_SW(tbsw), .PULSE_2P_SW(p2sw), .CURRENT_DIAL(cdial),
        .SPEED_FILTER_DIAL(fdial), .TORQUE_OVER_IN(torq), .PUSH_ACTIVE_IN(push), .DEVIATION_IN(dev),
        .ROTOR_QSTEP_IN(qstep), .ROTOR_FWD_IN(fwd), .FAULT_IN(flt), .FAULT_CODE_IN(code),
        .FAULT_RESETTABLE_IN(resbl), .FAULT_KEEP_CURRENT_IN(keep), .WARN_IN(warn), .READY_OUT(rdy),
        .TORQUE_LIMIT_OUT(torque_limit_out), .END_OUT(endo), .TIMING_OUT_DIFF(tdiff), .TIMING_OUT_OC(toc),
        .FEEDBACK_PHASE_A(pa), .FEEDBACK_PHASE_B(pb), .WARNING_OUT(warning_out), .ALARM_OUT(alarm_out),
        .ALARM_LED(led), .MOTOR_ENABLE(men), .BRAKE_HOLD(brk), .RES_SECOND_ACTIVE(res2),
        .PULSE_MODE_2P(p2), .CURRENT_RATE(rate), .FILTER_MS(fms));

    sds_ctrl_model ctrl_u (.clk(clk_r), .ready(rdy), .alarm_ok(alarm_out), .run(run), .step(step));

    // ****************************************
    // check, bus and closing tasks
    // ****************************************
    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // one classic cycle, held until ack is sampled
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_r);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) n_errors++;
        @(posedge clk_r);
    endtask

    task wrap_up;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk_r);
        n_errors++;
        wrap_up;
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clk_r);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_r);
        wb(0, CTRL_OFF, 0);
        chk(q, CTRL_RST);
        wb(0, ENDWIN_OFF, 0);
        chk(q, 32'h0000_00B4);
        wb(0, DIALS_OFF, 0);
        chk(q, 32'h0000_0732);
        wb(0, 4'h2, 0);
        chk(q, 32'h0000_0000);
        chk({rate, fms}, {5'h07, 8'h32});
        chk({p2, res2, rdy, men}, 4'b1000);
        exc <= 1'b1;
        repeat (20) if (rdy !== 1'b1) @(posedge clk_r);
        chk({men, rdy}, 2'b11);
        wb(0, STATUS_OFF, 0);
        chk(q[1:0], 2'b11);
        // 160 quarter steps forward, 4 back; rsel held still
        for (int i = 1; i <= 164; i++) begin
            qstep <= 1'b1;
            fwd <= (i <= 160);
            @(posedge clk_r);
            qstep <= 1'b0;
            repeat (4) @(posedge clk_r);
            p = (i <= 160) ? i : 320 - i;
            chk({pa, pb}, {p[1] ^ p[0], p[1]});
            nd += (tdiff === 1'b1);
            no += (toc === 1'b1);
            repeat (45) @(posedge clk_r);
        end
        chk(nd, 2);
        chk(no, 2);
        // motion complete window and step activity
        repeat (20) @(posedge clk_r);
        chk(endo, 1);
        dev <= 16'sh00B5;
        repeat (4) @(posedge clk_r);
        chk(endo, 0);
        dev <= -16'sh00B4;
        repeat (4) @(posedge clk_r);
        chk(endo, 1);
        run <= 1'b1;
        repeat (8) @(posedge clk_r);
        chk(endo, 0);
        run <= 1'b0;
        repeat (40) @(posedge clk_r);
        chk(endo, 1);
        // torque limit and push
        torq <= 1'b1;
        repeat (3) @(posedge clk_r);
        chk(torque_limit_out, 1);
        torq <= 1'b0;
        push <= 1'b1;
        repeat (3) @(posedge clk_r);
        chk(torque_limit_out, 0);
        wb(1, CTRL_OFF, 32'h0000_0008);
        repeat (2) @(posedge clk_r);
        chk(torque_limit_out, 1);
        push <= 1'b0;
        // excitation removed and restored
        exc <= 1'b0;
        repeat (8) @(posedge clk_r);
        chk({men, rdy}, 2'b00);
        exc <= 1'b1;
        repeat (20) if (rdy !== 1'b1) @(posedge clk_r);
        chk(rdy, 1);
        // resettable alarm with code output and warning
        wb(1, CTRL_OFF, 32'h0000_0003);
        flt <= 1'b1;
        code <= 3'd5;
        @(posedge clk_r);
        flt <= 1'b0;
        repeat (3) @(posedge clk_r);
        chk({alarm_out, men, brk, warning_out}, 4'b0011);
        chk({rdy, torque_limit_out, toc}, 3'b101);
        repeat (12) if (led !== 1'b1) @(posedge clk_r);
        chk(led, 1);
        clr <= 1'b1;
        repeat (6) @(posedge clk_r);
        clr <= 1'b0;
        repeat (10) @(posedge clk_r);
        chk({alarm_out, men, brk}, 3'b110);
        chk({rdy, torque_limit_out, toc}, 3'b100);
        // current kept, clear refused
        flt <= 1'b1;
        code <= 3'd2;
        keep <= 1'b1;
        resbl <= 1'b0;
        @(posedge clk_r);
        flt <= 1'b0;
        repeat (3) @(posedge clk_r);
        chk({alarm_out, men}, 2'b01);
        clr <= 1'b1;
        repeat (6) @(posedge clk_r);
        clr <= 1'b0;
        repeat (10) @(posedge clk_r);
        chk(alarm_out, 0);
        // select toggled away from a timing position: timing is lost
        rsel <= 1'b1;
        repeat (6) @(posedge clk_r);
        chk(res2, 1);
        wb(0, STATUS_OFF, 0);
        chk(q[11], 1);
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
